/* File: fwg_guard.sv */
// command and protection sequencer with spi link front end
`timescale 1ns/1ps
`default_nettype none
module fwg_guard
    import fwg_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    input wire logic hw_lock_n_in,
    input wire logic op_done_in,
    output logic ready_busy_flag_out,
    output logic erase_suspended_flag_out,
    output logic program_suspended_flag_out,
    output logic write_permit_latch_out,
    output logic complement_select_out,
    output logic [4:0] guard_level_out,
    output logic op_start_out,
    output logic [1:0] op_kind_out,
    output logic [19:0] op_addr_out,
    output logic op_resume_out,
    output logic op_suspend_out,
    output logic prot_reject_out
);
    // link domain: opcode and address capture on the spi clock
    logic first_reg;
    logic [6:0] shift_reg;
    logic [2:0] bit_reg;
    logic [2:0] byte_reg;
    logic frame_tog_reg;
    logic [7:0] lk_op_reg;
    logic [7:0] lk_b1_reg;
    logic [19:0] lk_addr_reg;
    logic [7:0] in_byte;
    assign in_byte = {shift_reg, spi_mosi_in};

    // chip select high presets the first-bit marker; the clock may be stopped then
    always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    always_ff @(posedge spi_clk_in) begin
        shift_reg <= in_byte[6:0];
        if (first_reg) begin
            bit_reg <= 3'h1;
            byte_reg <= '0;
        end else begin
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7 && byte_reg != BYTE_SAT) begin
                byte_reg <= byte_reg + 3'h1;
            end
        end
    end

    // cleared while the link clock is parked; an unknown toggle would hide every frame end
    always_ff @(posedge spi_clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_tog_reg <= 1'b0;
        end else if (first_reg) begin
            frame_tog_reg <= ~frame_tog_reg;
        end
    end

    // only the first four bytes are kept; later ones are dropped
    always_ff @(posedge spi_clk_in) begin
        if (!first_reg && bit_reg == 3'h7) begin
            case (byte_reg)
                3'h0: lk_op_reg <= in_byte;
                3'h1: begin
                    lk_b1_reg <= in_byte;
                    lk_addr_reg[19:16] <= in_byte[3:0];
                end
                3'h2: lk_addr_reg[15:8] <= in_byte;
                3'h3: lk_addr_reg[7:0] <= in_byte;
                default: lk_op_reg <= lk_op_reg;
            endcase
        end
    end

    // reference domain: synchronise chip select, lock pin and frame toggle
    logic [2:0] sync_q;
    logic cs_s;
    logic lock_n_s;
    logic tog_s;
    logic cs_d_reg;
    logic tog_seen_reg;
    fwg_sync #(.W(3), .RST_VAL(SYNC_RESET)) u_sync (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in({frame_tog_reg, hw_lock_n_in, spi_cs_n_in}),
        .q_out(sync_q)
    );
    assign cs_s = sync_q[0];
    assign lock_n_s = sync_q[1];
    assign tog_s = sync_q[2];

    // link registers are read only after chip select rose, when the link clock is idle;
    // a frame with no clock edge leaves the toggle unchanged and is dropped
    logic frame_end;
    logic aligned;
    logic frame_any;
    logic fr_ok;
    assign frame_end = cs_s && !cs_d_reg && (tog_s != tog_seen_reg);
    assign aligned = (bit_reg == 3'h0);
    assign frame_any = frame_end && (byte_reg >= BYTES_OPC);
    assign fr_ok = frame_any && aligned;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cs_d_reg <= 1'b1;
            tog_seen_reg <= 1'b0;
        end else begin
            cs_d_reg <= cs_s;
            if (cs_s && !cs_d_reg) begin
                tog_seen_reg <= tog_s;
            end
        end
    end

    // command decode
    logic is_array_op;
    logic is_wr_cmd;
    logic is_erase_kind;
    logic [2:0] need_bytes;
    logic [1:0] cmd_kind;
    logic [19:0] lo_addr;
    logic [19:0] hi_addr;
    logic check_prot;
    always_comb begin
        is_array_op = 1'b1;
        need_bytes = BYTES_ADDR;
        cmd_kind = KIND_PROG;
        check_prot = 1'b1;
        lo_addr = lk_addr_reg & ~MASK_PAGE;
        hi_addr = lk_addr_reg | MASK_PAGE;
        case (lk_op_reg)
            OP_PROG: cmd_kind = KIND_PROG;
            OP_SPROG: check_prot = 1'b0;
            // status write is two bytes; a refused one must not look short
            OP_WRSR: begin
                need_bytes = BYTES_SR;
                is_array_op = 1'b0;
                check_prot = 1'b0;
            end
            OP_SERASE: begin
                cmd_kind = KIND_ERASE;
                check_prot = 1'b0;
            end
            OP_BE4: begin
                cmd_kind = KIND_ERASE;
                lo_addr = lk_addr_reg & ~MASK_4K;
                hi_addr = lk_addr_reg | MASK_4K;
            end
            OP_BE32: begin
                cmd_kind = KIND_ERASE;
                lo_addr = lk_addr_reg & ~MASK_32K;
                hi_addr = lk_addr_reg | MASK_32K;
            end
            OP_BE64: begin
                cmd_kind = KIND_ERASE;
                lo_addr = lk_addr_reg & ~MASK_64K;
                hi_addr = lk_addr_reg | MASK_64K;
            end
            OP_CE1, OP_CE2: begin
                cmd_kind = KIND_CHIP;
                need_bytes = BYTES_OPC;
                lo_addr = '0;
                hi_addr = ADDR_LAST;
            end
            default: begin
                is_array_op = 1'b0;
                check_prot = 1'b0;
            end
        endcase
        is_wr_cmd = is_array_op || (lk_op_reg == OP_WRSR);
        is_erase_kind = (cmd_kind != KIND_PROG);
    end

    // regions are anchored at an array end, so testing both ends of a block covers it
    logic hit_lo;
    logic hit_hi;
    logic tgt_prot;
    fwg_prot_decode u_dec_lo (
        .cmp_in(complement_select_out),
        .level_in(guard_level_out),
        .addr_in(lo_addr),
        .hit_out(hit_lo)
    );
    fwg_prot_decode u_dec_hi (
        .cmp_in(complement_select_out),
        .level_in(guard_level_out),
        .addr_in(hi_addr),
        .hit_out(hit_hi)
    );
    assign tgt_prot = check_prot && (hit_lo || hit_hi);

    fwg_state_e st_reg;
    fwg_state_e st_next;
    logic [1:0] kind_reg;
    logic [8:0] rcnt_reg;
    logic enough;
    logic idle;
    logic susp_any;
    logic susp_allowed;
    logic start_ok;
    logic prot_rej;
    logic sr_ok;
    logic abort_clr;
    logic resume_ok;
    logic suspend_ok;
    assign enough = byte_reg >= need_bytes;
    assign idle = (st_reg == FWG_ST_IDLE);
    assign susp_any = erase_suspended_flag_out || program_suspended_flag_out;
    assign susp_allowed = !program_suspended_flag_out
        && !(is_erase_kind && erase_suspended_flag_out);
    assign start_ok = fr_ok && is_array_op && enough && write_permit_latch_out && idle
        && susp_allowed && !tgt_prot;
    assign prot_rej = fr_ok && is_array_op && enough && write_permit_latch_out && idle
        && susp_allowed && tgt_prot;
    assign sr_ok = fr_ok && lk_op_reg == OP_WRSR && byte_reg >= BYTES_SR
        && write_permit_latch_out && idle && !susp_any && lock_n_s;
    assign abort_clr = frame_any && is_wr_cmd && idle && (!aligned || !enough);
    assign resume_ok = fr_ok && lk_op_reg == OP_RESUME && idle && susp_any;
    assign suspend_ok = fr_ok && lk_op_reg == OP_SUSPEND && st_reg == FWG_ST_RUN
        && kind_reg != KIND_CHIP && !(kind_reg == KIND_PROG && erase_suspended_flag_out)
        && !op_done_in;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            FWG_ST_IDLE: begin
                if (resume_ok) begin
                    st_next = FWG_ST_RESTART;
                end else if (start_ok) begin
                    st_next = FWG_ST_RUN;
                end
            end
            FWG_ST_RUN: begin
                if (op_done_in) begin
                    st_next = FWG_ST_IDLE;
                end else if (suspend_ok) begin
                    st_next = FWG_ST_IDLE;
                end
            end
            FWG_ST_RESTART: begin
                // suspend frames are not looked at here
                if (op_done_in) begin
                    st_next = FWG_ST_IDLE;
                end else if (rcnt_reg == '0) begin
                    st_next = FWG_ST_RUN;
                end
            end
            default: st_next = FWG_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st_reg <= FWG_ST_IDLE;
            ready_busy_flag_out <= 1'b0;
            rcnt_reg <= '0;
        end else begin
            st_reg <= st_next;
            ready_busy_flag_out <= (st_next != FWG_ST_IDLE);
            if (resume_ok) begin
                rcnt_reg <= 9'(RESTART_CYC - 1);
            end else if (rcnt_reg != '0) begin
                rcnt_reg <= rcnt_reg - 9'h1;
            end
        end
    end

    // suspended flags and the kind of the running operation
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            erase_suspended_flag_out <= 1'b0;
            program_suspended_flag_out <= 1'b0;
            kind_reg <= KIND_NONE;
        end else if (resume_ok) begin
            if (program_suspended_flag_out) begin
                program_suspended_flag_out <= 1'b0;
                kind_reg <= KIND_PROG;
            end else begin
                erase_suspended_flag_out <= 1'b0;
                kind_reg <= KIND_ERASE;
            end
        end else if (suspend_ok) begin
            if (kind_reg == KIND_PROG) begin
                program_suspended_flag_out <= 1'b1;
            end else begin
                erase_suspended_flag_out <= 1'b1;
            end
            kind_reg <= KIND_NONE;
        end else if (start_ok) begin
            kind_reg <= cmd_kind;
        end else if (op_done_in && !idle) begin
            kind_reg <= KIND_NONE;
        end
    end

    // write-permit latch; cleared at start so a finishing operation finds it low
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            write_permit_latch_out <= 1'b0;
        end else if (fr_ok && lk_op_reg == OP_WREN) begin
            write_permit_latch_out <= 1'b1;
        end else if (fr_ok && lk_op_reg == OP_WRDI) begin
            write_permit_latch_out <= 1'b0;
        end else if (start_ok || prot_rej || sr_ok || abort_clr) begin
            write_permit_latch_out <= 1'b0;
        end
    end

    // protection bits; reset load stands in for the non-volatile contents
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            complement_select_out <= PROT_RESET[CMP_POS];
            guard_level_out <= PROT_RESET[4:0];
        end else if (sr_ok) begin
            complement_select_out <= lk_b1_reg[CMP_POS];
            guard_level_out <= lk_b1_reg[4:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            op_start_out <= 1'b0;
            op_kind_out <= KIND_NONE;
            op_addr_out <= '0;
            op_resume_out <= 1'b0;
            op_suspend_out <= 1'b0;
            prot_reject_out <= 1'b0;
        end else begin
            op_start_out <= start_ok;
            op_resume_out <= resume_ok;
            op_suspend_out <= suspend_ok;
            prot_reject_out <= prot_rej;
            if (start_ok) begin
                op_kind_out <= cmd_kind;
                op_addr_out <= lk_addr_reg;
            end
        end
    end

    a_resume_busy: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        resume_ok |=> (ready_busy_flag_out && op_resume_out)
        ##1 (ready_busy_flag_out && !op_resume_out))
        else $error("resume did not report busy");
    a_resume_drop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (fr_ok && lk_op_reg == OP_RESUME && (!susp_any || !idle)) |=>
        !op_resume_out && $stable({erase_suspended_flag_out, program_suspended_flag_out}))
        else $error("resume taken when it should be ignored");
    a_resume_nowel: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (fr_ok && lk_op_reg == OP_RESUME && idle && susp_any && !write_permit_latch_out)
        |=> op_resume_out)
        else $error("resume refused without latch");
    a_prog_first: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (resume_ok && program_suspended_flag_out && erase_suspended_flag_out) |=>
        !program_suspended_flag_out && erase_suspended_flag_out && op_resume_out)
        else $error("program not resumed first");
    a_resume_align: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (frame_end && lk_op_reg == OP_RESUME && !aligned) |=> !op_resume_out)
        else $error("misaligned resume acted");
    a_restart_nosusp: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (st_reg == FWG_ST_RESTART && fr_ok && lk_op_reg == OP_SUSPEND && !op_done_in) |=>
        !op_suspend_out && ready_busy_flag_out)
        else $error("suspend taken during restart");
    a_wren: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (fr_ok && lk_op_reg == OP_WREN) |=> write_permit_latch_out)
        else $error("write enable did not set latch");
    a_wrdi: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (fr_ok && lk_op_reg == OP_WRDI) |=> !write_permit_latch_out)
        else $error("write disable did not clear latch");
    a_wel_short: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (frame_end && !fr_ok && (lk_op_reg == OP_WREN || lk_op_reg == OP_WRDI)) |=>
        $stable(write_permit_latch_out))
        else $error("bad frame changed latch");
    a_lock: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !lock_n_s |=> $stable({complement_select_out, guard_level_out}))
        else $error("protection bits changed while locked");
    a_need_wel: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (fr_ok && is_array_op && !write_permit_latch_out) |=> !op_start_out)
        else $error("write command ran without latch");
    a_prot_rej: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        prot_rej |=> !write_permit_latch_out && !op_start_out && prot_reject_out)
        else $error("protected target not rejected");
    a_suspend: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        suspend_ok |=> !ready_busy_flag_out && susp_any)
        else $error("suspend did not set flag and ready");
endmodule
`default_nettype wire

/* File: fwg_pkg.sv */
// constants and types for the flash write guard and resume block
// Overview of operation
// - resume is taken only when a suspended flag is set and the device is ready
// - resume is dropped silently when nothing is suspended or the device is busy
// - resume needs no write-permit latch
// - resume is a bare opcode; bytes after it are ignored
// - valid resume at frame end clears its suspended flag and reports busy
// - resume needs a whole opcode and a frame ending on a byte boundary
// - with both suspended, program resumes first; a second resume restarts the erase
// - suspend requests are ignored while a resumed operation is restarting
// - opcode 06h sets the write-permit latch at frame end
// - program, erase and status writes run only with the write-permit latch set
// - short or misaligned 06h/04h frames leave the write-permit latch alone
// - opcode 04h clears the write-permit latch at frame end
// - complement and five guard-level bits change only by status write
// - complement 0, level bit4 0: fractions of the array, upper or lower end
// - complement 0, level bit4 1: 4K to 32K at top or bottom end
// - complement 1 protects exactly the complement of the selected region
// - lock pin never changes the region, it only gates protection updates
// - lock pin low rejects any change of the protection bits
// - successful suspend sets its suspended flag and reports ready
// - block or chip erase into a protected region is dropped and clears the latch; 44h skips the check
package fwg_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_BE4 = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE1 = 8'h60;
    localparam logic [7:0] OP_CE2 = 8'hc7;
    localparam logic [7:0] OP_SPROG = 8'h42;
    localparam logic [7:0] OP_SERASE = 8'h44;
    localparam int ADDR_W = 20;
    localparam logic [19:0] ADDR_LAST = 20'hfffff;
    localparam logic [20:0] ARRAY_SIZE = 21'h100000;
    localparam logic [20:0] SPAN_64K = 21'h010000;
    localparam logic [20:0] SPAN_4K = 21'h001000;
    localparam logic [20:0] SPAN_32K = 21'h008000;
    localparam logic [19:0] MASK_PAGE = 20'h000ff;
    localparam logic [19:0] MASK_4K = 20'h00fff;
    localparam logic [19:0] MASK_32K = 20'h07fff;
    localparam logic [19:0] MASK_64K = 20'h0ffff;
    localparam logic [2:0] BYTES_OPC = 3'h1;
    localparam logic [2:0] BYTES_SR = 3'h2;
    localparam logic [2:0] BYTES_ADDR = 3'h4;
    localparam logic [2:0] BYTE_SAT = 3'h7;
    localparam int CMP_POS = 5;
    localparam logic [5:0] PROT_RESET = 6'h00;
    localparam logic [2:0] SYNC_RESET = 3'h3;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RESTART_NS = 1000;
    localparam int RESTART_CYC = (RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_PROG = 2'h1;
    localparam logic [1:0] KIND_ERASE = 2'h2;
    localparam logic [1:0] KIND_CHIP = 2'h3;
    typedef enum logic [2:0] {
        FWG_ST_IDLE = 3'h1,
        FWG_ST_RUN = 3'h2,
        FWG_ST_RESTART = 3'h4
    } fwg_state_e;
endpackage

/* File: fwg_prot_decode.sv */
// protected-range decoder for one target address
`timescale 1ns/1ps
`default_nettype none
module fwg_prot_decode
    import fwg_pkg::*;
(
    input wire logic cmp_in,
    input wire logic [4:0] level_in,
    input wire logic [19:0] addr_in,
    output logic hit_out
);
    logic [20:0] len;
    logic [20:0] addr_w;
    logic all_prot;
    logic in_region;
    always_comb begin
        len = '0;
        all_prot = 1'b0;
        addr_w = {1'b0, addr_in};
        if (!level_in[4]) begin
            case (level_in[2:0])
                3'h0: len = '0;
                3'h1, 3'h2, 3'h3, 3'h4: len = 21'(SPAN_64K << (level_in[2:0] - 3'h1));
                default: all_prot = 1'b1;
            endcase
        end else begin
            case (level_in[2:0])
                3'h0: len = '0;
                3'h1, 3'h2, 3'h3: len = 21'(SPAN_4K << (level_in[2:0] - 3'h1));
                3'h4, 3'h5: len = SPAN_32K;
                default: all_prot = 1'b1;
            endcase
        end
        if (all_prot) begin
            in_region = 1'b1;
        end else if (level_in[3]) begin
            in_region = addr_w < len;
        end else begin
            in_region = addr_w >= (ARRAY_SIZE - len);
        end
        hit_out = in_region ^ cmp_in;
    end
endmodule
`default_nettype wire

/* File: fwg_spi_host.sv */
// spi host model that shifts whole frames into the guard block
`timescale 1ns/1ps
`default_nettype none
module fwg_spi_host (
    output logic spi_clk_out,
    output logic spi_cs_n_out,
    output logic spi_mosi_out
);
    initial begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end
    // mode 0, msb first, clock parked low outside frames
    // bit count is free so that misaligned frames can be sent on purpose
    task automatic xfer(input logic [31:0] data, input int nbits);
        #13.7;
        spi_cs_n_out = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_mosi_out = data[i];
            #32 spi_clk_out = 1'b1;
            #32 spi_clk_out = 1'b0;
        end
        #32 spi_cs_n_out = 1'b1;
        // released line shows the inverse so a stale bit is never trusted
        spi_mosi_out = ~spi_mosi_out;
        #40;
    endtask
endmodule
`default_nettype wire

/* File: fwg_sync.sv */
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module fwg_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    meta_reg[i] <= RST_VAL[i];
                    q_out[i] <= RST_VAL[i];
                end else begin
                    meta_reg[i] <= d_in[i];
                    q_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the write guard and resume block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fwg_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hw_lock_n_in = 1'b1;
    logic op_done_in = 1'b0;
    logic spi_clk, spi_cs_n, spi_mosi;
    logic busy, esus, psus, wpl, cmp, start, res, sus, rej;
    logic [4:0] lvl;
    logic [1:0] kind;
    logic [19:0] addr;
    int failures = 0;
    int checked = 0;
    int n_start = 0;
    int n_rej = 0;
    int n_res = 0;
    int n_sus = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    fwg_spi_host i_host (.spi_clk_out(spi_clk), .spi_cs_n_out(spi_cs_n),
        .spi_mosi_out(spi_mosi));
    fwg_guard i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .spi_clk_in(spi_clk),
        .spi_cs_n_in(spi_cs_n), .spi_mosi_in(spi_mosi), .hw_lock_n_in(hw_lock_n_in),
        .op_done_in(op_done_in), .ready_busy_flag_out(busy),
        .erase_suspended_flag_out(esus), .program_suspended_flag_out(psus),
        .write_permit_latch_out(wpl), .complement_select_out(cmp),
        .guard_level_out(lvl), .op_start_out(start), .op_kind_out(kind),
        .op_addr_out(addr), .op_resume_out(res), .op_suspend_out(sus),
        .prot_reject_out(rej));
    // pulses last one cycle, so they are counted rather than sampled late
    always @(posedge ref_clk_in) begin
        if (start === 1'b1) n_start++;
        if (rej === 1'b1) n_rej++;
        if (res === 1'b1) n_res++;
        if (sus === 1'b1) n_sus++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // decision and the registered outputs land together on the third ref edge after cs rises
    task automatic frame(input logic [31:0] d, input int n);
        i_host.xfer(d, n);
        repeat (12) @(posedge ref_clk_in);
    endtask
    task automatic done_pulse();
        @(posedge ref_clk_in) op_done_in <= 1'b1;
        @(posedge ref_clk_in) op_done_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
    endtask
    task automatic t_latch();
        frame(32'h06, 8);
        chk(wpl, 1);
        frame(32'h02, 7);
        chk(wpl, 1);
        frame(32'h04ff, 16);
        chk(wpl, 0);
        frame(32'h00d, 9);
        chk(wpl, 0);
        $display("latch test done");
    endtask
    task automatic t_resume();
        frame(32'h7a, 8);
        chk(busy, 0);
        frame(32'h20000000, 32);
        chk(n_start, 0);
        frame(32'h06, 8);
        frame(32'h20000000, 32);
        chk({n_start[7:0], 6'h00, kind, busy, wpl}, {8'h01, 6'h00, KIND_ERASE, 2'b10});
        frame(32'h75, 8);
        chk({esus, busy}, 2'b10);
        frame(32'h0f5, 9);
        chk({esus, busy}, 2'b10);
        chk(wpl, 0);
        frame(32'h7a00, 16);
        chk({esus, busy, n_res[3:0]}, 6'h11);
        // suspend sent inside the restart window on purpose
        frame(32'h75, 8);
        chk({esus, busy}, 2'b01);
        // wait out the restart window before suspending again
        repeat (100) @(posedge ref_clk_in);
        frame(32'h75, 8);
        chk({esus, busy, n_sus[3:0]}, 6'h22);
        frame(32'h7a, 8);
        done_pulse();
        chk(busy, 0);
        $display("resume test done");
    endtask
    task automatic t_guard();
        @(posedge ref_clk_in) hw_lock_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        frame(32'h06, 8);
        frame(32'h013f, 16);
        chk({cmp, lvl}, 6'h00);
        @(posedge ref_clk_in) hw_lock_n_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        frame(32'h06, 8);
        frame(32'h0101, 16);
        chk({cmp, lvl}, 6'h01);
        frame(32'h06, 8);
        frame(32'h200f0000, 32);
        chk({n_rej[3:0], wpl, busy}, 6'h04);
        frame(32'h06, 8);
        frame(32'h200e0000, 32);
        chk({n_start[3:0], addr}, {4'h2, 20'he0000});
        done_pulse();
        frame(32'h06, 8);
        frame(32'h0121, 16);
        chk({cmp, lvl}, 6'h21);
        frame(32'h06, 8);
        frame(32'h200e0000, 32);
        chk(n_rej, 2);
        frame(32'h06, 8);
        frame(32'h0111, 16);
        frame(32'h06, 8);
        frame(32'h200ff000, 32);
        frame(32'h06, 8);
        frame(32'h200fe000, 32);
        chk({n_rej[3:0], n_start[3:0], cmp, lvl}, {4'h3, 4'h3, 6'h11});
        done_pulse();
        @(posedge ref_clk_in) hw_lock_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        chk({cmp, lvl}, 6'h11);
        $display("guard test done");
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        t_latch();
        t_resume();
        t_guard();
        results();
    end
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        failures++;
        results();
    end
endmodule
`default_nettype wire
